// ==== ctmr_top.v ====
// carrier timer control, counting datapath, pending flags and apb slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ctmr_defs.vh"

// Notes on behaviour
// [RULE_01] the count clock is the system clock divided by 1, 2, 4 or 8 by control bits 7..6.
// [RULE_02] the undivided source is the clock currently chosen as system clock, here clk.
// [RULE_03] the interrupt time field picks low period, high period or both; 11 is invalid.
// [RULE_04] every carrier timer underflow selected by the field sets pending bit 2.
// [RULE_05] companion timer overflow sets pending bit 1, match or capture sets bit 0.
// [RULE_06] writing 0 to a pending bit clears it, writing 1 does not, all reset to 0.
// [RULE_07] control bit 3 enables the interrupt, 2 runs, 1 selects repeat, 0 sets the flop.
module ctmr_top
(
  // clock and reset
  input wire clk,
  input wire srst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // companion timer events, same clock
  input wire ta_overflow,
  input wire ta_match_capture,
  // timer outputs
  output reg output_toggle_flop,
  output wire irq
);

  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [7:0] carrier_timer_control;
  reg [7:0] low_data;
  reg [7:0] high_data;
  reg [2:0] irq_mask;
  reg [7:0] count;
  reg [2:0] state;
  reg [2:0] next_state;
  reg second_half;
  wire tick;
  wire [2:0] pend;
  wire acc;
  wire wr;
  wire mapped;
  wire underflow;
  wire tb_event;
  wire [1:0] int_sel;
  wire pend_wr;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function is_mapped;
    input [11:0] a;
    begin
      case (a)
        `CTMR_ADDR_PEND, `CTMR_ADDR_CTRL, `CTMR_ADDR_LOW,
        `CTMR_ADDR_HIGH, `CTMR_ADDR_MASK, `CTMR_ADDR_STAT: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  assign acc = psel & penable;
  assign mapped = is_mapped(paddr);
  assign wr = acc & pwrite & mapped;
  // zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign pend_wr = wr & (paddr == `CTMR_ADDR_PEND);

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      carrier_timer_control <= `CTMR_RST_CTRL;
      low_data <= `CTMR_RST_DATA;
      high_data <= `CTMR_RST_DATA;
      irq_mask <= `CTMR_RST_MASK;
    end
    else if (wr)
    begin
      case (paddr)
        `CTMR_ADDR_CTRL: carrier_timer_control <= pwdata[7:0]; // [RULE_07]
        `CTMR_ADDR_LOW: low_data <= pwdata[7:0];
        `CTMR_ADDR_HIGH: high_data <= pwdata[7:0];
        `CTMR_ADDR_MASK: irq_mask <= pwdata[2:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // read data is captured in the setup cycle so it stands through access
  always @(posedge clk)
  begin
    if (srst)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
    begin
      case (paddr)
        `CTMR_ADDR_PEND: prdata <= {29'h0000_0000, pend};
        `CTMR_ADDR_CTRL: prdata <= {24'h00_0000, carrier_timer_control};
        `CTMR_ADDR_LOW: prdata <= {24'h00_0000, low_data};
        `CTMR_ADDR_HIGH: prdata <= {24'h00_0000, high_data};
        `CTMR_ADDR_MASK: prdata <= {29'h0000_0000, irq_mask};
        `CTMR_ADDR_STAT: prdata <= {20'h0_0000, state, output_toggle_flop, count};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // count clock divider
  // ------------------------------------------------------------
  ctmr_div u_div
  (
    .clk(clk),
    .srst(srst),
    .div_sel(carrier_timer_control[`CTMR_CTL_DIV_HI:`CTMR_CTL_DIV_LO]), // [RULE_01]
    .tick(tick)
  );

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  // a one-shot run ends after the low and high periods; rewriting control restarts it
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (carrier_timer_control[`CTMR_CTL_RUN]) // [RULE_07]
          next_state = ST_RUN;
      ST_RUN:
        if (~carrier_timer_control[`CTMR_CTL_RUN])
          next_state = ST_IDLE;
        else if (underflow & second_half & ~carrier_timer_control[`CTMR_CTL_RPT]) // [RULE_07]
          next_state = ST_DONE;
      ST_DONE:
        if (wr & (paddr == `CTMR_ADDR_CTRL))
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ------------------------------------------------------------
  // counting datapath
  // ------------------------------------------------------------
  assign underflow = (state == ST_RUN) & carrier_timer_control[`CTMR_CTL_RUN] & tick &
    (count == 8'h00);

  // while stopped the flop follows the control bit and the count is preloaded
  always @(posedge clk)
  begin
    if (srst)
    begin
      count <= `CTMR_RST_DATA;
      output_toggle_flop <= 1'b0;
      second_half <= 1'b0;
    end
    else if (state == ST_IDLE)
    begin
      output_toggle_flop <= carrier_timer_control[`CTMR_CTL_OUT]; // [RULE_07]
      count <= carrier_timer_control[`CTMR_CTL_OUT] ? high_data : low_data;
      second_half <= 1'b0;
    end
    else if (underflow)
    begin
      output_toggle_flop <= ~output_toggle_flop;
      count <= output_toggle_flop ? low_data : high_data;
      second_half <= ~second_half;
    end
    else if ((state == ST_RUN) & tick)
      count <= count - 8'h01;
  end

  // ------------------------------------------------------------
  // interrupt time selection and pending flags
  // ------------------------------------------------------------
  assign int_sel = carrier_timer_control[`CTMR_CTL_INT_HI:`CTMR_CTL_INT_LO];
  // code 11 is invalid and raises nothing
  assign tb_event = underflow &
    (((int_sel == `CTMR_INT_LOW) & ~output_toggle_flop) |
     ((int_sel == `CTMR_INT_HIGH) & output_toggle_flop) |
     (int_sel == `CTMR_INT_BOTH)); // [RULE_03]

  ctmr_pend #(.WIDTH(`CTMR_PEND_W)) u_pend
  (
    .clk(clk),
    .srst(srst),
    .set({tb_event, ta_overflow, ta_match_capture}), // [RULE_04] [RULE_05]
    .wr_en(pend_wr), // [RULE_06]
    .wr_data(pwdata[2:0]),
    .flags(pend)
  );

  // underflow enable gates only the carrier timer flag onto the line
  assign irq = |(pend & irq_mask &
    {carrier_timer_control[`CTMR_CTL_UFIE], 2'b11}); // [RULE_07]

endmodule // ctmr_top
`default_nettype wire

// ==== ctmr_defs.vh ====
// register map, field positions and reset values of the carrier timer block
`ifndef CTMR_DEFS_VH
`define CTMR_DEFS_VH

// ------------------------------------------------------------
// register indices and byte addresses
// ------------------------------------------------------------
`define CTMR_IDX_PEND 8'hf2
`define CTMR_IDX_CTRL 8'hf8
`define CTMR_ADDR_PEND 12'h3c8
`define CTMR_ADDR_CTRL 12'h3e0
`define CTMR_ADDR_LOW 12'h400
`define CTMR_ADDR_HIGH 12'h404
`define CTMR_ADDR_MASK 12'h408
`define CTMR_ADDR_STAT 12'h40c
`define CTMR_ADDR_W 12

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTMR_CTL_DIV_HI 7
`define CTMR_CTL_DIV_LO 6
`define CTMR_CTL_INT_HI 5
`define CTMR_CTL_INT_LO 4
`define CTMR_CTL_UFIE 3
`define CTMR_CTL_RUN 2
`define CTMR_CTL_RPT 1
`define CTMR_CTL_OUT 0

// ------------------------------------------------------------
// interrupt time selection codes
// ------------------------------------------------------------
`define CTMR_INT_LOW 2'h0
`define CTMR_INT_HIGH 2'h1
`define CTMR_INT_BOTH 2'h2

// ------------------------------------------------------------
// divider selection codes
// ------------------------------------------------------------
`define CTMR_DIV_1 2'h0
`define CTMR_DIV_2 2'h1
`define CTMR_DIV_4 2'h2
`define CTMR_DIV_8 2'h3

// ------------------------------------------------------------
// pending flag positions and reset values
// ------------------------------------------------------------
`define CTMR_PEND_TAMC 0
`define CTMR_PEND_TAOV 1
`define CTMR_PEND_TBUF 2
`define CTMR_PEND_W 3
`define CTMR_RST_CTRL 8'h00
`define CTMR_RST_PEND 3'h0
`define CTMR_RST_DATA 8'h00
`define CTMR_RST_MASK 3'h0

`endif

// ==== ctmr_div.v ====
// count clock divider: one-cycle enable pulses at clk/1, /2, /4 or /8
`timescale 1ns/1ps
`default_nettype none
`include "ctmr_defs.vh"

module ctmr_div
(
  // clock and reset
  input wire clk,
  input wire srst,
  // control
  input wire [1:0] div_sel,
  // output
  output reg tick
);

  reg [2:0] div_cnt;

  // ------------------------------------------------------------
  // free running prescaler
  // ------------------------------------------------------------
  // the undivided source is clk itself, i.e. the selected system clock
  always @(posedge clk)
  begin
    if (srst)
      div_cnt <= 3'h0;
    else
      div_cnt <= div_cnt + 3'h1;
  end

  always @*
  begin
    case (div_sel) // [RULE_01] [RULE_02]
      `CTMR_DIV_1: tick = 1'b1;
      `CTMR_DIV_2: tick = (div_cnt[0] == 1'b1);
      `CTMR_DIV_4: tick = (div_cnt[1:0] == 2'h3);
      default: tick = (div_cnt == 3'h7);
    endcase
  end

endmodule // ctmr_div
`default_nettype wire

// ==== ctmr_pend.v ====
// pending flags: hardware sets, software clears by writing zero
`timescale 1ns/1ps
`default_nettype none
`include "ctmr_defs.vh"

module ctmr_pend
#(
  parameter WIDTH = 3
)
(
  // clock and reset
  input wire clk,
  input wire srst,
  // event pulses
  input wire [WIDTH-1:0] set,
  // software write
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  // flags
  output reg [WIDTH-1:0] flags
);

  // ------------------------------------------------------------
  // flag storage
  // ------------------------------------------------------------
  // a zero clears, a one leaves the flag alone; a set in the same cycle wins
  always @(posedge clk)
  begin
    if (srst)
      flags <= {WIDTH{1'b0}}; // [RULE_06]
    else if (wr_en)
      flags <= (flags & wr_data) | set; // [RULE_06]
    else
      flags <= flags | set; // [RULE_04] [RULE_05]
  end

endmodule // ctmr_pend
`default_nettype wire

// ==== ctmr_notes_end.v ====
// empty marker file intentionally omitted

// ==== ctmr_monitor.sv ====
// port checker for the carrier timer block
`timescale 1ns/1ps
`default_nettype none
`include "ctmr_defs.vh"
module ctmr_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // events and outputs
  input wire logic ta_overflow,
  input wire logic ta_match_capture,
  input wire logic output_toggle_flop,
  input wire logic irq
);
  // --------
  // shadows
  // --------
  // bit 2 of pending is not visible here, only the companion flags are mirrored
  logic [7:0] ctl;
  logic [2:0] msk;
  logic [1:0] ta;
  wire wr = psel & penable & pwrite & pready;
  wire rd = psel & penable & !pwrite & pready;
  always_ff @(posedge clk)
    if (srst)
    begin
      ctl <= 8'h00;
      msk <= 3'h0;
      ta <= 2'h0;
    end
    else
    begin
      if (wr && paddr == `CTMR_ADDR_CTRL)
        ctl <= pwdata[7:0];
      if (wr && paddr == `CTMR_ADDR_MASK)
        msk <= pwdata[2:0];
      if (wr && paddr == `CTMR_ADDR_PEND)
        ta <= (ta & pwdata[1:0]) | {ta_overflow, ta_match_capture};
      else
        ta <= ta | {ta_overflow, ta_match_capture};
    end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence cfg_held;
    $stable(ctl) ##1 $stable(ctl);
  endsequence
  // ----------
  // assertions
  // ----------
  AST_PEND_RD: assert property (rd && paddr == `CTMR_ADDR_PEND |->
    prdata[1:0] == $past(ta) && prdata[31:3] == 29'h0) else $error("pending readback wrong");
  AST_CTRL_RD: assert property (rd && paddr == `CTMR_ADDR_CTRL |->
    prdata == {24'h0, $past(ctl)}) else $error("control readback wrong");
  AST_RST_IRQ: assert property (disable iff (1'b0) srst |=> !irq)
    else $error("irq after reset");
  AST_FLOP_STOP: assert property (cfg_held ##0 !ctl[2] |->
    output_toggle_flop == ctl[0]) else $error("stopped flop level wrong");
  AST_IRQ_GATE: assert property (msk == 3'h0 || (msk == 3'h4 && !ctl[3]) |-> !irq)
    else $error("irq not gated");
  AST_IRQ_TA: assert property ((ta & msk[1:0]) != 2'h0 |-> irq)
    else $error("irq missing for companion flag");
  AST_INT_TIME: assert property ($rose(irq) && $stable(msk) && $stable(ctl) && msk == 3'h4
    |-> (ctl[5:4] == 2'h0 && $rose(output_toggle_flop)) ||
    (ctl[5:4] == 2'h1 && $fell(output_toggle_flop)) ||
    (ctl[5:4] == 2'h2 && $changed(output_toggle_flop))) else $error("irq at wrong time");
  // unmapped access phases must flag an error, mapped ones must not
  AST_SLVERR: assert property (psel && penable |-> pready && pslverr ==
    !(paddr == `CTMR_ADDR_PEND || paddr == `CTMR_ADDR_CTRL || paddr == `CTMR_ADDR_LOW ||
    paddr == `CTMR_ADDR_HIGH || paddr == `CTMR_ADDR_MASK || paddr == `CTMR_ADDR_STAT))
    else $error("slave error flag wrong");
endmodule // ctmr_monitor
bind ctmr_top ctmr_monitor ctmr_monitor_inst (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .ta_overflow(ta_overflow),
  .ta_match_capture(ta_match_capture), .output_toggle_flop(output_toggle_flop), .irq(irq));
`default_nettype wire

// ==== ctmr_top_test.sv ====
// self-checking bench for the carrier timer block
`timescale 1ns/1ps
`default_nettype none
`include "ctmr_defs.vh"
module ctmr_top_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ta_overflow = 1'b0, ta_match_capture = 1'b0;
  wire pready, pslverr, output_toggle_flop, irq;
  wire [31:0] prdata;
  logic [31:0] expq[$];
  logic [31:0] exp_v;
  integer n_errors = 0, n_compared = 0, seed = 32'h5e12, i, k, r, d, c;
  always #50 clk = ~clk;
  ctmr_top ctmr_top_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .ta_overflow(ta_overflow), .ta_match_capture(ta_match_capture),
    .output_toggle_flop(output_toggle_flop), .irq(irq));
  // -----
  // tasks
  // -----
  task automatic test_done;
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, want);
    end
  endtask
  // a read passes its expectation as the data word
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    integer w;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    if (!wr) expq.push_back(dat);
    @(posedge clk);
    penable <= 1'b1;
    w = 0;
    @(posedge clk);
    while (pready !== 1'b1 && w < 20)
    begin
      w++;
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // register updates land in the nba region, so look at settled outputs
    @(negedge clk);
    if (w >= 20)
    begin
      n_errors++;
      test_done;
    end
  endtask
  task automatic wait_lvl(input logic lvl);
    c = 0;
    while (output_toggle_flop !== lvl && c < 400)
    begin
      @(posedge clk);
      c++;
    end
    if (c >= 400)
    begin
      n_errors++;
      test_done;
    end
  endtask
  // read results are matched in issue order
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      exp_v = expq.size() ? expq.pop_front() : 32'hx;
      chk(prdata, exp_v);
    end
  // --------
  // sequence
  // --------
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, `CTMR_ADDR_CTRL, 32'h0);
    apb(1'b0, `CTMR_ADDR_PEND, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      r = $random(seed);
      d = r & 32'hfb;
      if (d[5:4] == 2'h3) d[4] = 1'b0;
      apb(1'b1, `CTMR_ADDR_CTRL, d);
      apb(1'b0, `CTMR_ADDR_CTRL, d);
      chk({31'h0, output_toggle_flop}, {31'h0, d[0]});
    end
    @(posedge clk);
    ta_overflow <= 1'b1;
    @(posedge clk);
    ta_overflow <= 1'b0;
    ta_match_capture <= 1'b1;
    @(posedge clk);
    ta_match_capture <= 1'b0;
    apb(1'b0, `CTMR_ADDR_PEND, 32'h3);
    apb(1'b1, `CTMR_ADDR_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `CTMR_ADDR_PEND, 32'h7);
    apb(1'b0, `CTMR_ADDR_PEND, 32'h3);
    apb(1'b1, `CTMR_ADDR_PEND, 32'h5);
    apb(1'b0, `CTMR_ADDR_PEND, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `CTMR_ADDR_PEND, 32'h0);
    apb(1'b1, `CTMR_ADDR_MASK, 32'h4);
    apb(1'b1, `CTMR_ADDR_LOW, 32'h1);
    apb(1'b1, `CTMR_ADDR_HIGH, 32'h2);
    // high phase of data 2 lasts three count ticks at each divider
    for (k = 0; k < 4; k++)
    begin
      r = (k == 3) ? 2 : k;
      apb(1'b1, `CTMR_ADDR_CTRL, {24'h0, k[1:0], r[1:0], 4'hf});
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      chk(c, 3 << k);
      apb(1'b0, `CTMR_ADDR_PEND, 32'h4);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `CTMR_ADDR_PEND, 32'h0);
    end
    apb(1'b1, `CTMR_ADDR_CTRL, 32'h0);
    test_done;
  end
endmodule // ctmr_top_test
`default_nettype wire
